// ===== llupc_regs.sv
`timescale 1ns/1ps
// config-space latency and usb port/clock register bank
// How it works
// - fundamental, global or power-on reset restores defaults
// - first silicon pass: latency register reads zero, inert
// - latency resets 0x1b; reserved bits read zero
// - bits 5:3 feed reported l1 acceptable latency
// - l1 code doubles per step, default 4-8us
// - bits 2:0 feed reported l0s acceptable latency
// - l0s code doubles per step, default 256-512ns
// - usb register resets zero; bit 31 stops ssc
// - writing commit bit restarts the oscillator
// - commit bit writable once per global or power-on reset
// - strap high lets rate code drive pll
// - rate code locked once commit is set
// - conceal bit zeroes next pointer and bars 2,3
// - sense bit picks enable polarity and pulldowns
// - bit 16 reports power switch support inverted
// - bits 8-11 disable ports one through four
// - two-port variant ignores port 3,4 disables
// - sticky bits survive fundamental reset only
module llupc_regs #(
  parameter int NUM_PORTS   = 4,
  parameter bit FIRST_PASS  = 1'b0
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  global_reset_pin_n,
  input  wire logic                  por_reset,
  input  wire logic                  cfg_wr,
  input  wire logic                  cfg_rd,
  input  wire logic [7:0]            cfg_addr,
  input  wire logic [3:0]            cfg_be,
  input  wire logic [31:0]           cfg_wdata,
  output logic      [31:0]           cfg_rdata,
  output logic                       cfg_hit,
  input  wire logic                  rate_strap_pin,
  output logic      [2:0]            l1_accept_exit_delay,
  output logic      [2:0]            l0s_accept_exit_delay,
  output logic                       ssc_off,
  output logic                       osc_restart,
  output logic      [5:0]            pll_rate_code,
  output logic                       pll_rate_override,
  output logic      [7:0]            next_cap_ptr,
  output logic                       bar23_zero,
  input  wire logic [3:0]            port_power_request,
  output logic      [3:0]            port_power_enable_out,
  output logic                       pulldown_enable,
  output logic                       power_switch_capable,
  output logic      [3:0]            port_off
);
  import llupc_pkg::*;

  initial begin
    if (NUM_PORTS != 2 && NUM_PORTS != 4) begin
      $error("NUM_PORTS must be 2 or 4");
    end
  end

  logic [1:0]  gr_sync_ff;
  logic        strap_meta_ff;
  logic        strap_ff;
  logic        hard_reset;
  logic        any_reset;
  logic [31:0] wr_bits;
  logic        lat_wr;
  logic        usb_wr;
  logic [5:0]  lat_ff;
  logic [5:0]  nxt_lat;
  logic [9:0]  usbv_ff;
  logic [9:0]  nxt_usbv;
  logic        commit_q;
  logic        commit_prev_ff;
  logic [5:0]  rate_q;
  logic        sense_q;
  logic [31:0] lat_read;
  logic [31:0] usb_read;
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;
  logic        restart_ff;
  logic        nxt_restart;

  // global reset pin is asynchronous, two stages before use
  always_ff @(posedge clock) begin
    gr_sync_ff    <= {gr_sync_ff[0], global_reset_pin_n};
    strap_meta_ff <= rate_strap_pin;
    strap_ff      <= strap_meta_ff;
  end

  // por_reset is assumed to come from on-chip logic on this clock
  assign hard_reset = por_reset | gr_sync_ff[1] == 1'b0;
  assign any_reset  = reset | hard_reset;

  // byte enables widened to a bit mask
  assign wr_bits = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
  assign lat_wr  = cfg_wr && cfg_addr == LAT_OFFSET && !FIRST_PASS;
  assign usb_wr  = cfg_wr && cfg_addr == USB_OFFSET;

  // volatile fields; only writable bits are touched
  always_comb begin
    nxt_lat  = lat_ff;
    nxt_usbv = usbv_ff;
    if (lat_wr) begin
      nxt_lat = (lat_ff & ~wr_bits[5:0]) | (cfg_wdata[5:0] & wr_bits[5:0]);
    end
    if (usb_wr && cfg_be[3]) begin
      nxt_usbv[9] = cfg_wdata[USB_SSC_BIT];
    end
    if (usb_wr && cfg_be[2]) begin
      nxt_usbv[8] = cfg_wdata[USB_CONCEAL_BIT];
      nxt_usbv[4] = cfg_wdata[USB_NOSW_BIT];
    end
    if (usb_wr && cfg_be[1]) begin
      nxt_usbv[3:0] = cfg_wdata[USB_PORT_LSB +: 4];
    end
    nxt_usbv[7:5] = 3'b000;
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      lat_ff  <= LAT_RESET[5:0];
      usbv_ff <= 10'h000;
    end else begin
      lat_ff  <= nxt_lat;
      usbv_ff <= nxt_usbv;
    end
  end

  // sticky group lives on the hard reset only
  llupc_sticky u_sticky (
    .clock      (clock),
    .hard_reset (hard_reset),
    .wr_en      (usb_wr && cfg_be[3] && cfg_be[2] && !reset),
    .wr_data    ({cfg_wdata[USB_COMMIT_BIT], cfg_wdata[29:24], cfg_wdata[USB_SENSE_BIT]}),
    .commit_ff  (commit_q),
    .rate_ff    (rate_q),
    .sense_ff   (sense_q)
  );

  // restart pulse on the rising edge of the commit bit
  always_comb begin
    nxt_restart = commit_q && !commit_prev_ff;
  end

  always_ff @(posedge clock) begin
    if (hard_reset) begin
      commit_prev_ff <= 1'b0;
      restart_ff     <= 1'b0;
    end else begin
      commit_prev_ff <= commit_q;
      restart_ff     <= nxt_restart;
    end
  end

  // read images with reserved bits as zero
  assign lat_read = FIRST_PASS ? 32'h00000000 : {26'h0000000, lat_ff};
  assign usb_read = {usbv_ff[9], commit_q, rate_q, usbv_ff[8], sense_q,
                     5'h00, usbv_ff[4], 4'h0, usbv_ff[3:0], 8'h00};

  // address decode for reads; unmapped offsets return zero
  always_comb begin
    nxt_rdata = rdata_ff;
    if (cfg_rd) begin
      if (cfg_addr == LAT_OFFSET) begin
        nxt_rdata = lat_read;
      end else if (cfg_addr == USB_OFFSET) begin
        nxt_rdata = usb_read;
      end else begin
        nxt_rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign cfg_rdata = rdata_ff;
  assign cfg_hit   = cfg_addr == LAT_OFFSET || cfg_addr == USB_OFFSET;

  // reported latencies; first pass keeps the reset defaults as inert values
  assign l1_accept_exit_delay  = FIRST_PASS ? LAT_RESET[5:3] : lat_ff[5:3];
  assign l0s_accept_exit_delay = FIRST_PASS ? LAT_RESET[2:0] : lat_ff[2:0];

  assign ssc_off              = usbv_ff[9];
  assign osc_restart          = restart_ff;
  assign pll_rate_override    = strap_ff;
  assign pll_rate_code        = strap_ff ? rate_q : 6'h00;
  assign next_cap_ptr         = usbv_ff[8] ? NEXT_CAP_NONE : NEXT_CAP_PTR;
  assign bar23_zero           = usbv_ff[8];
  assign power_switch_capable = ~usbv_ff[4];
  assign pulldown_enable      = ~sense_q;
  // low sense means active-low pins: invert the request
  assign port_power_enable_out = sense_q ? (port_power_request & ~port_off)
                                         : ~(port_power_request & ~port_off);
  // absent ports are forced off; the disable bit there has nothing to steer
  assign port_off = (NUM_PORTS == 2) ? {2'b11, usbv_ff[1:0]} : usbv_ff[3:0];

  a_reset_defaults: assert property (@(posedge clock)
    reset |=> lat_ff == LAT_RESET[5:0] && usbv_ff == 10'h000)
    else $error("volatile fields not at default after reset");
  a_lat_reserved: assert property (@(posedge clock) disable iff (any_reset)
    cfg_rd && cfg_addr == LAT_OFFSET |=> cfg_rdata[31:6] == 26'h0)
    else $error("latency reserved bits nonzero");
  a_usb_reserved: assert property (@(posedge clock) disable iff (any_reset)
    cfg_rd && cfg_addr == USB_OFFSET |=> cfg_rdata[21:17] == 5'h0 && cfg_rdata[15:12] == 4'h0)
    else $error("usb reserved bits nonzero");
  a_lat_write: assert property (@(posedge clock) disable iff (any_reset)
    lat_wr && cfg_be[0] |=> l1_accept_exit_delay == $past(cfg_wdata[5:3]))
    else $error("l1 field not taken from write");
  a_sticky_hold: assert property (@(posedge clock) disable iff (hard_reset)
    reset |=> sense_q == $past(sense_q))
    else $error("sticky bit lost on fundamental reset");
  a_restart_pulse: assert property (@(posedge clock) disable iff (hard_reset)
    $rose(commit_q) |=> osc_restart ##1 !osc_restart)
    else $error("oscillator restart not a single pulse");
  a_conceal_ptr: assert property (@(posedge clock) disable iff (any_reset)
    usb_wr && cfg_be[2] && cfg_wdata[USB_CONCEAL_BIT] |=> next_cap_ptr == NEXT_CAP_NONE)
    else $error("next pointer not cleared");
  a_port_off: assert property (@(posedge clock) disable iff (any_reset)
    usb_wr && cfg_be[1] |=> port_off[1:0] == $past(cfg_wdata[9:8]))
    else $error("port disable not applied");
  a_nosw_flag: assert property (@(posedge clock) disable iff (any_reset)
    usb_wr && cfg_be[2] |=> power_switch_capable == !$past(cfg_wdata[USB_NOSW_BIT]))
    else $error("power switch report wrong");

  // first pass: latency register reads zero and never takes a write
  a_pass1_read: assert property (@(posedge clock) disable iff (any_reset)
    FIRST_PASS && cfg_rd && cfg_addr == LAT_OFFSET |=> cfg_rdata == 32'h00000000)
    else $error("first pass latency read not zero");
  a_pass1_inert: assert property (@(posedge clock) disable iff (any_reset)
    FIRST_PASS |-> lat_ff == LAT_RESET[5:0])
    else $error("first pass latency field moved");

  // default codes after reset: 4-8us for l1, 256-512ns for l0s
  a_l1_default: assert property (@(posedge clock)
    reset |=> l1_accept_exit_delay == LAT_RESET[5:3])
    else $error("l1 default code wrong");
  a_l0s_default: assert property (@(posedge clock)
    reset |=> l0s_accept_exit_delay == LAT_RESET[2:0])
    else $error("l0s default code wrong");

  // low byte lane carries both latency fields; a write without it leaves them alone
  a_l0s_write: assert property (@(posedge clock) disable iff (any_reset)
    lat_wr && cfg_be[0] |=> l0s_accept_exit_delay == $past(cfg_wdata[2:0]))
    else $error("l0s field not taken from write");
  a_lat_lane_off: assert property (@(posedge clock) disable iff (any_reset)
    lat_wr && !cfg_be[0] |=> $stable(lat_ff))
    else $error("latency field changed without its byte lane");

  // spread-spectrum stop and usb defaults
  a_ssc_write: assert property (@(posedge clock) disable iff (any_reset)
    usb_wr && cfg_be[3] |=> ssc_off == $past(cfg_wdata[USB_SSC_BIT]))
    else $error("ssc stop bit not taken from write");
  a_usb_defaults: assert property (@(posedge clock)
    reset |=> !ssc_off && !bar23_zero && power_switch_capable && port_off[1:0] == 2'b00)
    else $error("usb volatile outputs not at default after reset");

  // the restart pulse only follows a fresh commit
  a_restart_commit: assert property (@(posedge clock) disable iff (hard_reset)
    osc_restart |-> commit_q)
    else $error("oscillator restart without commit");
  a_restart_idle: assert property (@(posedge clock) disable iff (hard_reset)
    !commit_q |=> !osc_restart)
    else $error("oscillator restart while uncommitted");

  // strap decides whether the rate code reaches the pll at all
  a_strap_low_code: assert property (@(posedge clock) disable iff (hard_reset)
    !strap_ff |-> pll_rate_code == 6'h00 && !pll_rate_override)
    else $error("rate code leaks with strap low");
  a_strap_high_code: assert property (@(posedge clock) disable iff (hard_reset)
    strap_ff |-> pll_rate_code == rate_q && pll_rate_override)
    else $error("rate code not driven with strap high");

  // concealed vector capability also blanks bars 2 and 3
  a_conceal_bars: assert property (@(posedge clock) disable iff (any_reset)
    usb_wr && cfg_be[2] |=> bar23_zero == $past(cfg_wdata[USB_CONCEAL_BIT]))
    else $error("bar blanking not taken from write");
  a_ptr_default: assert property (@(posedge clock) disable iff (any_reset)
    !bar23_zero |-> next_cap_ptr == NEXT_CAP_PTR)
    else $error("next pointer lost while visible");

  // power-enable polarity and pulldowns follow the sense bit
  a_sense_write: assert property (@(posedge clock) disable iff (any_reset)
    usb_wr && cfg_be[3] && cfg_be[2] |=> sense_q == $past(cfg_wdata[USB_SENSE_BIT]))
    else $error("sense bit not taken from write");
  a_pulldown_sense: assert property (@(posedge clock) disable iff (hard_reset)
    pulldown_enable != sense_q)
    else $error("pulldown not opposite to sense");
  a_enable_low: assert property (@(posedge clock) disable iff (hard_reset)
    !sense_q && port_power_request[0] && !port_off[0] |-> !port_power_enable_out[0])
    else $error("active-low enable not driven low");
  a_enable_high: assert property (@(posedge clock) disable iff (hard_reset)
    sense_q && port_power_request[0] && !port_off[0] |-> port_power_enable_out[0])
    else $error("active-high enable not driven high");

  // upper ports: real disables on four ports, forced off when absent
  a_absent_ports: assert property (@(posedge clock)
    NUM_PORTS == 2 |-> port_off[3:2] == 2'b11)
    else $error("absent ports not held off");
  a_upper_ports: assert property (@(posedge clock) disable iff (any_reset)
    NUM_PORTS == 4 && usb_wr && cfg_be[1] |=> port_off[3:2] == $past(cfg_wdata[11:10]))
    else $error("upper port disable not applied");

  // unmapped offsets and the unowned low byte read as zero
  a_unmapped_zero: assert property (@(posedge clock) disable iff (any_reset)
    cfg_rd && !cfg_hit |=> cfg_rdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_usb_low_zero: assert property (@(posedge clock) disable iff (any_reset)
    cfg_rd && cfg_addr == USB_OFFSET |=> cfg_rdata[7:0] == 8'h00)
    else $error("usb low byte not zero");

  // hard reset clears the sticky group and any pending restart
  a_hard_clears: assert property (@(posedge clock)
    hard_reset |=> !commit_q && rate_q == 6'h00 && !sense_q && !osc_restart)
    else $error("sticky group not cleared by hard reset");
endmodule : llupc_regs

// ===== llupc_pkg.sv
// package: offsets, field positions, reset values for latency and usb config registers
package llupc_pkg;
  localparam logic [7:0]  LAT_OFFSET      = 8'hdc;
  localparam logic [7:0]  USB_OFFSET      = 8'he0;
  localparam logic [31:0] LAT_RESET       = 32'h0000001b;
  localparam logic [31:0] USB_RESET       = 32'h00000000;
  localparam logic [31:0] LAT_WMASK       = 32'h0000003f;
  // bits 7:0 are kept out of this block and read as zero here
  localparam logic [31:0] USB_WMASK       = 32'hffc10f00;
  localparam int          LAT_L1_LSB      = 3;
  localparam int          LAT_L0S_LSB     = 0;
  localparam int          USB_SSC_BIT     = 31;
  localparam int          USB_COMMIT_BIT  = 30;
  localparam int          USB_RATE_LSB    = 24;
  localparam int          USB_CONCEAL_BIT = 23;
  localparam int          USB_SENSE_BIT   = 22;
  localparam int          USB_NOSW_BIT    = 16;
  localparam int          USB_PORT_LSB    = 8;
  localparam logic [7:0]  NEXT_CAP_PTR    = 8'h71;
  localparam logic [7:0]  NEXT_CAP_NONE   = 8'h00;
endpackage : llupc_pkg

// ===== llupc_sticky.sv
`timescale 1ns/1ps
// sticky config bits: cleared only by global or power-on reset, with one-shot commit
module llupc_sticky (
  input  wire logic       clock,
  input  wire logic       hard_reset,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic            commit_ff,
  output logic [5:0]      rate_ff,
  output logic            sense_ff
);
  logic       nxt_commit;
  logic [5:0] nxt_rate;
  logic       nxt_sense;
  logic       written_ff;
  logic       nxt_written;

  // wr_data: [7]=commit, [6:1]=rate, [0]=sense
  always_comb begin
    nxt_commit  = commit_ff;
    nxt_rate    = rate_ff;
    nxt_sense   = sense_ff;
    nxt_written = written_ff;
    if (wr_en) begin
      nxt_sense = wr_data[0];
      if (!commit_ff) begin
        nxt_rate = wr_data[6:1];
      end
      if (!written_ff) begin
        nxt_commit  = wr_data[7];
        nxt_written = 1'b1;
      end
    end
  end

  // hard_reset excludes the pcie fundamental reset on purpose
  always_ff @(posedge clock) begin
    if (hard_reset) begin
      commit_ff  <= 1'b0;
      rate_ff    <= 6'h00;
      sense_ff   <= 1'b0;
      written_ff <= 1'b0;
    end else begin
      commit_ff  <= nxt_commit;
      rate_ff    <= nxt_rate;
      sense_ff   <= nxt_sense;
      written_ff <= nxt_written;
    end
  end

  a_commit_once: assert property (@(posedge clock) disable iff (hard_reset)
    written_ff && wr_en |=> commit_ff == $past(commit_ff))
    else $error("commit bit changed after first write");
  a_rate_locked: assert property (@(posedge clock) disable iff (hard_reset)
    commit_ff |=> rate_ff == $past(rate_ff))
    else $error("rate code changed while locked");
endmodule : llupc_sticky

// ===== llupc_host.sv
`timescale 1ns/1ps
// host model issuing one-cycle config strobes on the falling edge
module llupc_host (
  input  wire logic        clock,
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  input  wire logic [31:0] cfg_rdata
);
  // idle bus values at time zero
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h00000000;
  end

  // write strobe lasts one cycle; stale data is inverted so it cannot pass for valid
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clock);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = b;
    cfg_wdata = d;
    @(negedge clock);
    cfg_wr = 1'b0;
    cfg_wdata = ~d;
  endtask : wr

  // read data is registered at the taking edge and settled by the next falling edge
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(negedge clock);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge clock);
    cfg_rd = 1'b0;
    q = cfg_rdata;
  endtask : rd
endmodule : llupc_host

// ===== link_latency_and_usb_port_config_test.sv
`timescale 1ns/1ps
// self-checking bench for the latency and usb config register bank
module link_latency_and_usb_port_config_test;
  import llupc_pkg::*;
  logic clock, reset, global_reset_pin_n, por_reset, rate_strap_pin, cfg_hit;
  logic cfg_wr, cfg_rd, ssc_off, osc_restart, pll_rate_override, bar23_zero;
  logic pulldown_enable, power_switch_capable;
  logic [7:0] cfg_addr, next_cap_ptr;
  logic [3:0] cfg_be, port_power_request, port_power_enable_out, port_off;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [2:0] l1_accept_exit_delay, l0s_accept_exit_delay;
  logic [5:0] pll_rate_code;
  int miscompares, checks_done;
  logic [31:0] b_rdata;
  logic [2:0] b_l1, b_l0s;
  logic [3:0] b_port_off;

  llupc_host i_llupc_host (.clock(clock), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));

  llupc_regs i_llupc_regs (.clock(clock), .reset(reset),
    .global_reset_pin_n(global_reset_pin_n), .por_reset(por_reset), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit), .rate_strap_pin(rate_strap_pin),
    .l1_accept_exit_delay(l1_accept_exit_delay), .l0s_accept_exit_delay(l0s_accept_exit_delay),
    .ssc_off(ssc_off), .osc_restart(osc_restart), .pll_rate_code(pll_rate_code),
    .pll_rate_override(pll_rate_override), .next_cap_ptr(next_cap_ptr),
    .bar23_zero(bar23_zero), .port_power_request(port_power_request),
    .port_power_enable_out(port_power_enable_out), .pulldown_enable(pulldown_enable),
    .power_switch_capable(power_switch_capable), .port_off(port_off));

  // first-pass two-port build on the same bus; its read data, latencies and port disables are checked too
  llupc_regs #(.NUM_PORTS(2), .FIRST_PASS(1'b1)) i_llupc_regs_pass1 (.clock(clock),
    .reset(reset), .global_reset_pin_n(global_reset_pin_n), .por_reset(por_reset),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(b_rdata), .cfg_hit(), .rate_strap_pin(rate_strap_pin),
    .l1_accept_exit_delay(b_l1), .l0s_accept_exit_delay(b_l0s), .ssc_off(), .osc_restart(),
    .pll_rate_code(), .pll_rate_override(), .next_cap_ptr(), .bar23_zero(),
    .port_power_request(port_power_request), .port_power_enable_out(), .pulldown_enable(),
    .power_switch_capable(), .port_off(b_port_off));

  always #4 clock = ~clock;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_llupc_host.rd(a, q);
    chk("cfg_rdata", e, q);
  endtask : rchk

  task automatic report_and_stop;
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // watchdog: the sequence needs well under a hundred cycles
  initial begin
    repeat (2000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    global_reset_pin_n = 1'b1;
    // power-on reset alongside the fundamental one, else the sticky group starts unknown
    por_reset = 1'b1;
    rate_strap_pin = 1'b1;
    port_power_request = 4'h5;
    repeat (4) @(negedge clock);
    reset = 1'b0;
    por_reset = 1'b0;
    // defaults after reset, plus an unmapped offset
    rchk(LAT_OFFSET, 32'h0000001b);
    chk("hit", 32'(cfg_hit), 32'h1);
    rchk(USB_OFFSET, 32'h00000000);
    chk("l1", 32'(l1_accept_exit_delay), 32'h3);
    chk("l0s", 32'(l0s_accept_exit_delay), 32'h3);
    chk("switch_cap", 32'(power_switch_capable), 32'h1);
    chk("next_ptr", 32'(next_cap_ptr), 32'h71);
    chk("override", 32'(pll_rate_override), 32'h1);
    rchk(8'he4, 32'h00000000);
    chk("hit", 32'(cfg_hit), 32'h0);
    // latency fields accept only bits 5:0
    i_llupc_host.wr(LAT_OFFSET, 4'hf, 32'hffffffff);
    rchk(LAT_OFFSET, 32'h0000003f);
    chk("pass1_rdata", b_rdata, 32'h00000000);
    chk("pass1_l1", 32'(b_l1), 32'h3);
    chk("pass1_l0s", 32'(b_l0s), 32'h3);
    chk("l1", 32'(l1_accept_exit_delay), 32'h7);
    chk("l0s", 32'(l0s_accept_exit_delay), 32'h7);
    // committing write: restart pulse one cycle after the taking edge
    i_llupc_host.wr(USB_OFFSET, 4'hf, 32'hd5c10f00);
    chk("restart", 32'(osc_restart), 32'h0);
    @(negedge clock);
    chk("restart", 32'(osc_restart), 32'h1);
    @(negedge clock);
    chk("restart", 32'(osc_restart), 32'h0);
    rchk(USB_OFFSET, 32'hd5c10f00);
    chk("ssc_off", 32'(ssc_off), 32'h1);
    chk("rate", 32'(pll_rate_code), 32'h15);
    chk("next_ptr", 32'(next_cap_ptr), 32'h00);
    chk("bar23", 32'(bar23_zero), 32'h1);
    chk("switch_cap", 32'(power_switch_capable), 32'h0);
    chk("port_off", 32'(port_off), 32'hf);
    chk("pwr_en", 32'(port_power_enable_out), 32'h0);
    chk("pulldown", 32'(pulldown_enable), 32'h0);
    // commit and rate are locked, the rest clears
    i_llupc_host.wr(USB_OFFSET, 4'hf, 32'h00000000);
    rchk(USB_OFFSET, 32'h55000000);
    chk("rate", 32'(pll_rate_code), 32'h15);
    chk("pwr_en", 32'(port_power_enable_out), 32'ha);
    chk("pulldown", 32'(pulldown_enable), 32'h1);
    chk("port_off", 32'(port_off), 32'h0);
    chk("port_off_two", 32'(b_port_off), 32'hc);
    rate_strap_pin = 1'b0;
    repeat (3) @(negedge clock);
    chk("rate", 32'(pll_rate_code), 32'h00);
    chk("override", 32'(pll_rate_override), 32'h0);
    // fundamental reset keeps the sticky group
    i_llupc_host.wr(USB_OFFSET, 4'hf, 32'h00400000);
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    rchk(USB_OFFSET, 32'h55400000);
    rchk(LAT_OFFSET, 32'h0000001b);
    // global pin clears everything, sync delay allowed for
    global_reset_pin_n = 1'b0;
    repeat (3) @(negedge clock);
    global_reset_pin_n = 1'b1;
    repeat (4) @(negedge clock);
    rchk(USB_OFFSET, 32'h00000000);
    i_llupc_host.wr(USB_OFFSET, 4'hf, 32'h40000000);
    por_reset = 1'b1;
    @(negedge clock);
    por_reset = 1'b0;
    rchk(USB_OFFSET, 32'h00000000);
    report_and_stop();
  end
endmodule : link_latency_and_usb_port_config_test
